// *** foar_map.vh ***
`ifndef FOAR_MAP_VH
`define FOAR_MAP_VH
// ************************************************************
// Instruction fields
// ************************************************************
`define FOAR_MAJOR_FLOAT 4'hf
`define FOAR_MODE_ACC 3'h0
`define FOAR_MODE_DEF 3'h1
`define FOAR_MODE_AINC 3'h2
`define FOAR_MODE_AINC_DEF 3'h3
`define FOAR_MODE_ADEC 3'h4
`define FOAR_MODE_ADEC_DEF 3'h5
`define FOAR_MODE_IDX 3'h6
`define FOAR_MODE_IDX_DEF 3'h7
`define FOAR_REG_PC 3'h7
`define FOAR_ACC_LAST_ALL 3'h5
// ************************************************************
// Address steps in bytes, transfer sizes in 16-bit words
// ************************************************************
`define FOAR_STEP_SINGLE 16'h0004
`define FOAR_STEP_DOUBLE 16'h0008
`define FOAR_STEP_WORD 16'h0002
`define FOAR_WORDS_IMM 3'h1
`define FOAR_WORDS_SINGLE 3'h2
`define FOAR_WORDS_DOUBLE 3'h4
`define FOAR_WORDS_INT16 3'h1
`define FOAR_WORDS_INT32 3'h2
// ************************************************************
// Fraction path
// ************************************************************
`define FOAR_FRAC_W 60
`define FOAR_LSB_SINGLE 60'h000000800000000
`define FOAR_LSB_DOUBLE 60'h000000000000008
`define FOAR_KEEP_SINGLE 60'hffffff800000000
`define FOAR_KEEP_DOUBLE 60'hffffffffffffff8
`define FOAR_RND_SINGLE 6'd34
`define FOAR_RND_DOUBLE 6'd2
`define FOAR_EXP_MAX 12'sh0ff
// ************************************************************
// Exception codes
// ************************************************************
`define FOAR_EC_NONE 4'h0
`define FOAR_EC_DIV0 4'h4
`define FOAR_EC_OVF 4'h8
`define FOAR_EC_UNF 4'ha
`define FOAR_EC_UNDEF 4'hc
`define FOAR_EC_BADACC 4'h2
`endif

// *** foar_acc_mem.v ***
`timescale 1ns/1ps
`default_nettype none
module foar_acc_mem #(
  parameter DEPTH = 6,
  parameter WIDTH = 64,
  parameter AW = 3
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en && wr_addr < DEPTH) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Out of range reads return zero rather than stale data
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      if (rd_addr < DEPTH) begin
        rd_data_q <= mem[rd_addr];
      end else begin
        rd_data_q <= {WIDTH{1'b0}};
      end
    end
  end
endmodule // foar_acc_mem
`default_nettype wire

// *** foar_core.v ***
`timescale 1ns/1ps
`default_nettype none
`include "foar_map.vh"
module foar_core #(
  parameter NUM_ACC = 6
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Mode bits
  input wire double_precision_select,
  input wire long_integer_select,
  input wire chop_select,
  input wire overflow_trap_enable,
  input wire underflow_trap_enable,
  input wire undefined_variable_trap_enable,
  input wire late_model_select,
  // Instruction and general register
  input wire instr_valid,
  input wire [15:0] instr,
  input wire [15:0] gr_value,
  input wire [15:0] index_word,
  input wire is_int_conv,
  // Addressing results
  output reg addr_valid_q,
  output reg float_instr_q,
  output reg [3:0] float_opcode_field_q,
  output reg [1:0] accumulator_select_q,
  output reg [2:0] mode_q,
  output reg [2:0] gr_sel_q,
  output reg use_acc_operand_q,
  output reg [2:0] acc_operand_q,
  output reg deferred_q,
  output reg [15:0] eff_addr_q,
  output reg gr_wr_q,
  output reg [15:0] gr_wr_data_q,
  output reg [2:0] xfer_words_q,
  output reg bad_acc_q,
  output wire [63:0] acc_rd_data_q,
  // Raw arithmetic result
  input wire res_valid,
  input wire [2:0] res_acc,
  input wire res_sign,
  input wire signed [11:0] res_exp,
  input wire [59:0] res_frac,
  input wire op_div,
  input wire divisor_zero,
  input wire operand_from_mem,
  input wire operand_neg_zero,
  // Shaped result
  output reg out_valid_q,
  output reg out_sign_q,
  output reg [7:0] out_exp_q,
  output reg [54:0] out_frac_q,
  output reg out_write_q,
  output reg trap_q,
  output reg [3:0] exception_code_reg_q,
  output reg overflow_flag_q,
  output reg underflow_q,
  output reg zero_flag_q,
  output reg neg_flag_q
);
  // ************************************************************
  // Helpers
  // ************************************************************
  // Shift that brings the leading one to bit 58
  function [5:0] foar_lead;
    input [58:0] f;
    integer i;
    reg [31:0] t;
    begin
      foar_lead = 6'd0;
      t = 32'd0;
      for (i = 0; i < 59; i = i + 1) begin
        if (f[i]) begin
          t = 58 - i;
          foar_lead = t[5:0];
        end
      end
    end
  endfunction

  // ************************************************************
  // Addressing decode
  // ************************************************************
  wire is_float = (instr[15:12] == `FOAR_MAJOR_FLOAT);
  wire [3:0] f_opc = instr[11:8];
  wire [1:0] f_acc = instr[7:6];
  wire [2:0] f_mode = instr[5:3];
  wire [2:0] f_reg = instr[2:0];
  wire imm = (f_mode == `FOAR_MODE_AINC) && (f_reg == `FOAR_REG_PC);

  reg [15:0] step;
  reg [15:0] ea_d;
  reg [15:0] grw_d;
  reg grw_en_d;
  reg defer_d;
  reg [2:0] words_d;
  reg bad_d;

  always @* begin
    // Integer conversions size by the long bit, floats by precision
    if (is_int_conv) begin
      words_d = long_integer_select ? `FOAR_WORDS_INT32 :
                `FOAR_WORDS_INT16;
    end else begin
      words_d = double_precision_select ? `FOAR_WORDS_DOUBLE :
                `FOAR_WORDS_SINGLE;
    end
    step = double_precision_select ? `FOAR_STEP_DOUBLE :
           `FOAR_STEP_SINGLE;
    if (is_int_conv) begin
      step = {13'h0000, words_d} << 1;
    end
    ea_d = gr_value;
    grw_d = gr_value;
    grw_en_d = 1'b0;
    defer_d = 1'b0;
    bad_d = 1'b0;
    case (f_mode)
      `FOAR_MODE_ACC: begin
        ea_d = 16'h0000;
        words_d = 3'h0;
        bad_d = (f_reg > `FOAR_ACC_LAST_ALL);
      end
      `FOAR_MODE_DEF: begin
        ea_d = gr_value;
      end
      `FOAR_MODE_AINC: begin
        ea_d = gr_value;
        grw_en_d = 1'b1;
        if (imm) begin
          grw_d = gr_value + `FOAR_STEP_WORD;
          words_d = `FOAR_WORDS_IMM;
        end else begin
          grw_d = gr_value + step;
        end
      end
      `FOAR_MODE_AINC_DEF: begin
        ea_d = gr_value;
        defer_d = 1'b1;
        grw_en_d = 1'b1;
        grw_d = gr_value + `FOAR_STEP_WORD;
      end
      `FOAR_MODE_ADEC: begin
        grw_d = gr_value - step;
        ea_d = gr_value - step;
        grw_en_d = 1'b1;
      end
      `FOAR_MODE_ADEC_DEF: begin
        grw_d = gr_value - `FOAR_STEP_WORD;
        ea_d = gr_value - `FOAR_STEP_WORD;
        defer_d = 1'b1;
        grw_en_d = 1'b1;
      end
      `FOAR_MODE_IDX: begin
        ea_d = gr_value + index_word;
      end
      `FOAR_MODE_IDX_DEF: begin
        ea_d = gr_value + index_word;
        defer_d = 1'b1;
      end
      default: begin
        ea_d = gr_value;
      end
    endcase
  end

  wire take = instr_valid && is_float;
  wire acc_rd = take && (f_mode == `FOAR_MODE_ACC) && !bad_d;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_valid_q <= 1'b0;
      float_instr_q <= 1'b0;
      float_opcode_field_q <= 4'h0;
      accumulator_select_q <= 2'h0;
      mode_q <= 3'h0;
      gr_sel_q <= 3'h0;
      use_acc_operand_q <= 1'b0;
      acc_operand_q <= 3'h0;
      deferred_q <= 1'b0;
      eff_addr_q <= 16'h0000;
      gr_wr_q <= 1'b0;
      gr_wr_data_q <= 16'h0000;
      xfer_words_q <= 3'h0;
      bad_acc_q <= 1'b0;
    end else begin
      addr_valid_q <= take;
      float_instr_q <= instr_valid && is_float;
      gr_wr_q <= take && grw_en_d && !bad_d;
      bad_acc_q <= take && bad_d;
      if (take) begin
        float_opcode_field_q <= f_opc;
        accumulator_select_q <= f_acc;
        mode_q <= f_mode;
        gr_sel_q <= f_reg;
        use_acc_operand_q <= (f_mode == `FOAR_MODE_ACC);
        acc_operand_q <= f_reg;
        deferred_q <= defer_d;
        eff_addr_q <= ea_d;
        gr_wr_data_q <= grw_d;
        xfer_words_q <= words_d;
      end
    end
  end

  // ************************************************************
  // Result shaping
  // ************************************************************
  reg [59:0] norm;
  reg [59:0] sum;
  reg signed [11:0] exp_n;
  reg [5:0] sh;
  reg rbit;
  reg is_zero;
  reg ovf;
  reg unf;
  reg trap_d;
  reg [3:0] ec_d;
  reg wr_d;
  reg [7:0] exp_o;
  reg [54:0] frac_o;
  reg sign_o;
  reg zero_o;

  always @* begin
    norm = res_frac;
    exp_n = res_exp;
    sh = 6'd0;
    sum = 60'h000000000000000;
    rbit = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    trap_d = 1'b0;
    ec_d = `FOAR_EC_NONE;
    wr_d = 1'b1;
    sign_o = res_sign;
    exp_o = 8'h00;
    frac_o = 55'h00000000000000;
    zero_o = 1'b0;
    is_zero = (res_frac == 60'h000000000000000);
    // Top bit catches the add carry; shift it back in
    if (res_frac[`FOAR_FRAC_W-1]) begin
      norm = res_frac >> 1;
      exp_n = res_exp + 12'sd1;
    end else if (!is_zero) begin
      sh = foar_lead(res_frac[58:0]);
      norm = res_frac << sh;
      exp_n = res_exp - $signed({6'd0, sh});
    end
    if (double_precision_select) begin
      rbit = norm[`FOAR_RND_DOUBLE];
      sum = norm & `FOAR_KEEP_DOUBLE;
      if (rbit && !chop_select) begin
        sum = sum + `FOAR_LSB_DOUBLE;
      end
    end else begin
      rbit = norm[`FOAR_RND_SINGLE];
      sum = norm & `FOAR_KEEP_SINGLE;
      if (rbit && !chop_select) begin
        sum = sum + `FOAR_LSB_SINGLE;
      end
    end
    // Rounding from all ones renormalizes; bounds hold exactly
    if (sum[59]) begin
      sum = sum >> 1;
      exp_n = exp_n + 12'sd1;
    end
    ovf = !is_zero && (exp_n > `FOAR_EXP_MAX);
    unf = !is_zero && (exp_n < 12'sd1);
    // Low eight bits give 400 octal off in either direction
    exp_o = exp_n[7:0];
    frac_o = sum[57:3];
    if (operand_neg_zero && operand_from_mem &&
        undefined_variable_trap_enable) begin
      trap_d = 1'b1;
      ec_d = `FOAR_EC_UNDEF;
      wr_d = 1'b0;
    end else if (op_div && divisor_zero) begin
      trap_d = 1'b1;
      ec_d = `FOAR_EC_DIV0;
      wr_d = 1'b0;
    end else if (is_zero) begin
      sign_o = 1'b0;
      exp_o = 8'h00;
      frac_o = 55'h00000000000000;
      zero_o = 1'b1;
    end else if (ovf) begin
      if (overflow_trap_enable) begin
        trap_d = 1'b1;
        ec_d = `FOAR_EC_OVF;
      end else if (late_model_select) begin
        sign_o = 1'b0;
        exp_o = 8'h00;
        frac_o = 55'h00000000000000;
        zero_o = 1'b1;
      end
    end else if (unf) begin
      if (underflow_trap_enable) begin
        trap_d = 1'b1;
        ec_d = `FOAR_EC_UNF;
      end else begin
        sign_o = 1'b0;
        exp_o = 8'h00;
        frac_o = 55'h00000000000000;
        zero_o = 1'b1;
      end
    end
    if (!double_precision_select) begin
      frac_o[31:0] = 32'h00000000;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_q <= 1'b0;
      out_sign_q <= 1'b0;
      out_exp_q <= 8'h00;
      out_frac_q <= 55'h00000000000000;
      out_write_q <= 1'b0;
      trap_q <= 1'b0;
      exception_code_reg_q <= `FOAR_EC_NONE;
      overflow_flag_q <= 1'b0;
      underflow_q <= 1'b0;
      zero_flag_q <= 1'b0;
      neg_flag_q <= 1'b0;
    end else begin
      out_valid_q <= res_valid;
      out_write_q <= res_valid && wr_d;
      trap_q <= res_valid && trap_d;
      if (take && bad_d) begin
        exception_code_reg_q <= `FOAR_EC_BADACC;
      end else if (res_valid && trap_d) begin
        exception_code_reg_q <= ec_d;
      end
      if (res_valid) begin
        out_sign_q <= sign_o;
        out_exp_q <= exp_o;
        out_frac_q <= frac_o;
        overflow_flag_q <= ovf && wr_d;
        underflow_q <= unf && wr_d;
        zero_flag_q <= zero_o;
        neg_flag_q <= sign_o && !zero_o;
      end
    end
  end

  // ************************************************************
  // Accumulator file
  // ************************************************************
  foar_acc_mem #(
    .DEPTH(NUM_ACC),
    .WIDTH(64),
    .AW(3)
  ) u_acc (
    .clock(clock),
    .rst_b(rst_b),
    .wr_en(res_valid && wr_d),
    .wr_addr(res_acc),
    .wr_data({sign_o, exp_o, frac_o}),
    .rd_en(acc_rd),
    .rd_addr(f_reg),
    .rd_data_q(acc_rd_data_q)
  );
endmodule // foar_core
`default_nettype wire

// *** foar_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module foar_props #(
  parameter NUM_ACC = 6
) (
  // Inputs
  input wire logic clock,
  input wire logic rst_b,
  input wire logic double_precision_select,
  input wire logic is_int_conv,
  input wire logic undefined_variable_trap_enable,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] gr_value,
  input wire logic res_valid,
  input wire logic op_div,
  input wire logic divisor_zero,
  input wire logic operand_from_mem,
  input wire logic operand_neg_zero,
  // Outputs
  input wire logic addr_valid_q,
  input wire logic use_acc_operand_q,
  input wire logic [2:0] mode_q,
  input wire logic [15:0] eff_addr_q,
  input wire logic gr_wr_q,
  input wire logic [15:0] gr_wr_data_q,
  input wire logic [2:0] xfer_words_q,
  input wire logic bad_acc_q,
  input wire logic out_write_q,
  input wire logic trap_q,
  input wire logic [3:0] exception_code_reg_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic [15:0] step = double_precision_select ? 16'h0008 : 16'h0004;
  wire logic [2:0] m = instr[5:3];
  wire logic [2:0] r = instr[2:0];
  wire logic undef = operand_neg_zero && operand_from_mem &&
    undefined_variable_trap_enable;
  sequence s_take;
    instr_valid && instr[15:12] == 4'hf;
  endsequence
  sequence s_res;
    res_valid;
  endsequence
  a_addr_latency: assert property (s_take |=> addr_valid_q)
    else $error("no addressing answer");
  a_nonfloat_ignored: assert property (
    !(instr_valid && instr[15:12] == 4'hf) |=> !addr_valid_q)
    else $error("addressing answer without float instruction");
  a_mode_zero_acc: assert property (
    addr_valid_q |-> use_acc_operand_q == (mode_q == 3'h0))
    else $error("accumulator operand flag wrong");
  a_autoinc_step: assert property (
    s_take ##0 (m == 3'h2 && r != 3'h7 && !is_int_conv) |=> gr_wr_q &&
    eff_addr_q == $past(gr_value) &&
    gr_wr_data_q == $past(gr_value) + $past(step))
    else $error("autoincrement wrong");
  a_autodec_step: assert property (
    s_take ##0 (m == 3'h4 && !is_int_conv) |=> gr_wr_q &&
    eff_addr_q == $past(gr_value) - $past(step) &&
    gr_wr_data_q == eff_addr_q)
    else $error("autodecrement wrong");
  a_immediate_word: assert property (
    s_take ##0 (m == 3'h2 && r == 3'h7) |=> xfer_words_q == 3'h1)
    else $error("immediate size wrong");
  a_acc_limit: assert property (
    s_take ##0 (m == 3'h0 && r >= NUM_ACC) |=>
    bad_acc_q && exception_code_reg_q == 4'h2)
    else $error("illegal accumulator accepted");
  a_div_zero_trap: assert property (
    s_res ##0 (op_div && divisor_zero && !undef) |=>
    trap_q && !out_write_q && exception_code_reg_q == 4'h4)
    else $error("zero divisor not trapped");
  a_undef_trap: assert property (
    s_res ##0 undef |=>
    trap_q && !out_write_q && exception_code_reg_q == 4'hc)
    else $error("minus zero from memory not trapped");
endmodule // foar_props
bind foar_core foar_props #(.NUM_ACC(NUM_ACC)) u_props (
  .clock(clock), .rst_b(rst_b),
  .double_precision_select(double_precision_select),
  .is_int_conv(is_int_conv),
  .undefined_variable_trap_enable(undefined_variable_trap_enable),
  .instr_valid(instr_valid), .instr(instr), .gr_value(gr_value),
  .res_valid(res_valid), .op_div(op_div), .divisor_zero(divisor_zero),
  .operand_from_mem(operand_from_mem),
  .operand_neg_zero(operand_neg_zero), .addr_valid_q(addr_valid_q),
  .use_acc_operand_q(use_acc_operand_q), .mode_q(mode_q),
  .eff_addr_q(eff_addr_q), .gr_wr_q(gr_wr_q), .gr_wr_data_q(gr_wr_data_q),
  .xfer_words_q(xfer_words_q), .bad_acc_q(bad_acc_q),
  .out_write_q(out_write_q), .trap_q(trap_q),
  .exception_code_reg_q(exception_code_reg_q)
);
`default_nettype wire

// *** foar_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module foar_cpu_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access
  input wire logic [2:0] rd_sel,
  input wire logic gr_wr_q,
  input wire logic [2:0] gr_sel_q,
  input wire logic [15:0] gr_wr_data_q,
  // Operand words
  output logic [15:0] gr_value,
  output logic [15:0] index_word
);
  logic [15:0] regs [0:7];
  logic [15:0] idx_q = 16'h1357;
  integer i;
  assign gr_value = regs[rd_sel];
  assign index_word = idx_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 8; i++) begin
        regs[i] <= {5'h0, i[2:0], 8'h20};
      end
    end else if (gr_wr_q) begin
      regs[gr_sel_q] <= gr_wr_data_q;
    end
  end
  // Index word moves every cycle so a late sample is seen
  always @(posedge clock) begin
    idx_q <= {idx_q[14:0], idx_q[15] ^ idx_q[13]};
  end
endmodule // foar_cpu_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********
  // Stimulus and outputs
  // ********
  localparam logic [59:0] F58 = 60'h400000000000000;
  localparam logic [59:0] F34 = 60'h000000400000000;
  localparam logic [54:0] S1 = 55'h100000000;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] md = 6'h0;
  logic long_sel = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0;
  logic int_conv = 1'b0;
  logic res_valid = 1'b0;
  logic [2:0] res_acc = 3'h3;
  logic res_sign = 1'b0;
  logic signed [11:0] res_exp = 12'sh0;
  logic [59:0] res_frac = 60'h0;
  logic [3:0] qual = 4'h0;
  wire [15:0] gr_value, index_word, eff_addr_q, gr_wr_data_q;
  wire addr_valid_q, deferred_q, gr_wr_q, bad_acc_q;
  wire out_valid_q, out_write_q, trap_q;
  wire [2:0] mode_q, gr_sel_q, xfer_words_q;
  wire [63:0] acc_rd_data_q;
  wire [7:0] out_exp_q;
  wire [54:0] out_frac_q;
  wire [3:0] ecode;
  wire float_instr_q, use_acc_q, out_sign_q, overflow_flag_q, underflow_q;
  wire zero_flag_q, neg_flag_q;
  wire [3:0] opc_q;
  wire [1:0] acs_q;
  wire [2:0] acc_op_q;
  wire [51:0] addr_got = {float_instr_q, opc_q, acs_q, mode_q, use_acc_q,
    acc_op_q, bad_acc_q, deferred_q, mode_q == 3'h0 ? 16'h0 : eff_addr_q,
    gr_wr_q, gr_wr_q ? gr_wr_data_q : 16'h0, xfer_words_q};
  wire [68:0] res_got = {out_write_q, trap_q, trap_q ? ecode : 4'h0,
    out_write_q ? out_exp_q : 8'h0, out_write_q ? out_frac_q : 55'h0};
  wire [4:0] flags = {out_sign_q, overflow_flag_q, underflow_q, zero_flag_q,
    neg_flag_q};
  logic [68:0] aq[$];
  logic [68:0] rq[$];
  integer errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer seed = 54297;
  always #2 clock = ~clock;
  foar_core #(.NUM_ACC(6)) uut (
    .clock(clock), .rst_b(rst_b),
    .double_precision_select(md[5]), .long_integer_select(long_sel),
    .chop_select(md[4]), .overflow_trap_enable(md[3]),
    .underflow_trap_enable(md[2]), .late_model_select(md[1]),
    .undefined_variable_trap_enable(md[0]),
    .instr_valid(instr_valid), .instr(instr), .gr_value(gr_value),
    .index_word(index_word), .is_int_conv(int_conv),
    .addr_valid_q(addr_valid_q), .float_instr_q(float_instr_q),
    .float_opcode_field_q(opc_q), .accumulator_select_q(acs_q),
    .mode_q(mode_q), .gr_sel_q(gr_sel_q), .use_acc_operand_q(use_acc_q),
    .acc_operand_q(acc_op_q), .deferred_q(deferred_q),
    .eff_addr_q(eff_addr_q), .gr_wr_q(gr_wr_q), .gr_wr_data_q(gr_wr_data_q),
    .xfer_words_q(xfer_words_q), .bad_acc_q(bad_acc_q),
    .acc_rd_data_q(acc_rd_data_q), .res_valid(res_valid),
    .res_acc(res_acc), .res_sign(res_sign), .res_exp(res_exp),
    .res_frac(res_frac), .op_div(qual[3]), .divisor_zero(qual[2]),
    .operand_from_mem(qual[1]), .operand_neg_zero(qual[0]),
    .out_valid_q(out_valid_q), .out_sign_q(out_sign_q),
    .out_exp_q(out_exp_q),
    .out_frac_q(out_frac_q), .out_write_q(out_write_q), .trap_q(trap_q),
    .exception_code_reg_q(ecode), .overflow_flag_q(overflow_flag_q),
    .underflow_q(underflow_q), .zero_flag_q(zero_flag_q),
    .neg_flag_q(neg_flag_q)
  );
  foar_cpu_model cpu (
    .clock(clock), .rst_b(rst_b), .rd_sel(instr[2:0]), .gr_wr_q(gr_wr_q),
    .gr_sel_q(gr_sel_q), .gr_wr_data_q(gr_wr_data_q),
    .gr_value(gr_value), .index_word(index_word)
  );
  // ********
  // Checking
  // ********
  task automatic chk(input logic [68:0] act, input logic [68:0] exp);
    cmp_count++;
    if (act !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [68:0] ok(input logic [7:0] e,
                                     input logic [54:0] f);
    return {2'b10, 4'h0, e, f};
  endfunction
  function automatic logic [68:0] tr(input logic w, input logic [3:0] c,
                                     input logic [7:0] e);
    return {w, 1'b1, c, e, 55'h0};
  endfunction
  // Expected addressing answer, noted at the taking edge
  always @(posedge clock) begin : note_addr
    logic [2:0] m;
    logic [2:0] r;
    logic [15:0] st;
    logic [15:0] ea;
    logic wr;
    m = instr[5:3];
    r = instr[2:0];
    if (rst_b && instr_valid && instr[15:12] == 4'hf) begin
      st = (m == 3'h2 && r == 3'h7) || m == 3'h3 || m == 3'h5 ? 16'h2 :
        md[5] ? 16'h8 : 16'h4;
      ea = m[2:1] == 2'b11 ? gr_value + index_word :
        m[2:1] == 2'b10 ? gr_value - st : gr_value;
      wr = m[2:1] == 2'b01 || m[2:1] == 2'b10;
      aq.push_back({1'b1, instr[11:8], instr[7:6], m, m == 3'h0, r,
        m == 3'h0 && r > 3'h5, m == 3'h3 || m == 3'h5 ||
        m == 3'h7, m == 3'h0 ? 16'h0 : ea, wr,
        wr ? (m[2] ? ea : gr_value + st) : 16'h0,
        m == 3'h0 ? 3'h0 : (m == 3'h2 && r == 3'h7) ? 3'h1 :
        int_conv ? (long_sel ? 3'h2 : 3'h1) : md[5] ? 3'h4 : 3'h2});
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (rst_b && addr_valid_q) begin
      if (aq.size() == 0) chk(69'h1, 69'h0);
      else chk(addr_got, aq.pop_front());
    end
    if (rst_b && out_valid_q) begin
      if (rq.size() == 0) chk(69'h1, 69'h0);
      else chk(res_got, rq.pop_front());
    end
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
  // ********
  // Sequence
  // ********
  task automatic ai(input logic [15:0] w);
    instr = w;
    instr_valid = 1'b1;
    @(posedge clock);
    #1;
  endtask
  task automatic rt(input logic [5:0] m, input logic [3:0] q,
                    input logic [11:0] e, input logic [59:0] f,
                    input logic [68:0] x);
    md = m;
    qual = q;
    res_exp = e;
    res_frac = f;
    res_valid = 1'b1;
    rq.push_back(x);
    @(posedge clock);
    #1;
  endtask
  initial begin : main
    integer i;
    logic [15:0] w;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (i = 0; i < 300; i++) begin
      w = 16'($random(seed));
      if (w[13]) w[15:12] = 4'hf;
      md[5] = w[12];
      long_sel = w[10];
      int_conv = w[5:3] == 3'h1 ? w[11] : 1'b0;
      ai(w);
    end
    instr_valid = 1'b0;
    $display("test addressing done");
    rt(6'h00, 4'h0, 12'h081, F58 | F34, ok(8'h81, S1));
    res_acc = 3'h4;
    rt(6'h10, 4'h0, 12'h081, F58 | F34, ok(8'h81, 55'h0));
    rt(6'h20, 4'h0, 12'h081, F58 | 60'h4, ok(8'h81, 55'h1));
    res_sign = 1'b1;
    rt(6'h30, 4'h0, 12'h040, F58 >> 1, ok(8'h3f, 55'h0));
    chk(flags, 5'h11);
    res_sign = 1'b0;
    rt(6'h30, 4'h0, 12'h040, F58 << 1, ok(8'h41, 55'h0));
    rt(6'h28, 4'h0, 12'h180, F58, tr(1'b1, 4'h8, 8'h80));
    chk(flags, 5'h08);
    rt(6'h22, 4'h0, 12'h180, F58, ok(8'h00, 55'h0));
    chk(flags, 5'h0a);
    rt(6'h20, 4'h0, 12'h180, F58, ok(8'h80, 55'h0));
    rt(6'h20, 4'h0, 12'hffb, F58, ok(8'h00, 55'h0));
    chk(flags, 5'h06);
    rt(6'h24, 4'h0, 12'hf80, F58, tr(1'b1, 4'ha, 8'h80));
    rt(6'h24, 4'h0, 12'h000, F58, tr(1'b1, 4'ha, 8'h00));
    rt(6'h20, 4'hc, 12'h081, F58, tr(1'b0, 4'h4, 8'h00));
    rt(6'h21, 4'h3, 12'h000, 60'h0, tr(1'b0, 4'hc, 8'h00));
    res_sign = 1'b1;
    rt(6'h21, 4'h1, 12'h000, 60'h0, ok(8'h00, 55'h0));
    chk(flags, 5'h02);
    res_sign = 1'b0;
    rt(6'h20, 4'h8, 12'h000, 60'h0, ok(8'h00, 55'h0));
    res_valid = 1'b0;
    $display("test result shaping done");
    ai(16'hf003);
    chk(acc_rd_data_q, {1'b0, 8'h81, S1});
    instr_valid = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(aq.size() + rq.size(), 69'h0);
    $display("test accumulator read done");
    summarize();
  end
endmodule // tb
`default_nettype wire
